// file: src/dgpio_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "dgpio_map.svh"
module dgpio_bank (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic narrow_port_reset_n,
   input wire logic wide_port_reset_n,
   input wire logic narrow_port_active,
   input wire logic wide_port_active,
   input wire logic [7:0] cfg_addr,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_wdata,
   output logic [7:0] cfg_rdata,
   input wire logic [11:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   output logic io_hit,
   input wire dgpio_pkg::dgpio_alt_src_t alt_src,
   input wire logic [7:0] narrow_port_pins_in,
   output logic [7:0] narrow_port_pins_out,
   output logic [7:0] narrow_port_pins_oe,
   input wire logic [7:0] wide_port_pins_in,
   output logic [7:0] wide_port_pins_out,
   output logic [7:0] wide_port_pins_oe
);
   logic [7:0] ctrl_r, base_hi_r, base_lo_r, n_alt_r, w_alt_r;
   logic [11:0] win_base;
   logic win_sel;
   logic [7:0] win_idx, acc_addr, acc_wdata, rd_mux;
   logic acc_wr, acc_rd;
   dgpio_pkg::dgpio_acc_t acc_src;
   logic [7:0] n_alt_val, w_alt_val;
   dgpio_pkg::dgpio_regs_t n_regs, w_regs;

   // window base and hit decode
   assign win_base = {base_hi_r[3:0], base_lo_r};
   assign win_sel = ctrl_r[`DGPIO_CTRL_WIN_BIT] &&
      (io_addr[11:`DGPIO_WIN_SPAN_BITS] ==
       win_base[11:`DGPIO_WIN_SPAN_BITS]); // RL13 RL14
   assign io_hit = win_sel && (io_wr || io_rd);

   // window offset 0-3 narrow port, 4-7 wide port
   always_comb begin
      if (io_addr[2]) win_idx = `DGPIO_OFF_W_DIR | {6'h00, io_addr[1:0]};
      else win_idx = `DGPIO_OFF_N_DIR | {6'h00, io_addr[1:0]};
   end

   // configuration port wins over the window
   always_comb begin
      if (cfg_wr || cfg_rd) acc_src = dgpio_pkg::DGPIO_ACC_CFG;
      else if (io_hit) acc_src = dgpio_pkg::DGPIO_ACC_WIN;
      else acc_src = dgpio_pkg::DGPIO_ACC_IDLE;
   end

   always_comb begin
      case (acc_src)
         dgpio_pkg::DGPIO_ACC_CFG: begin
            acc_addr = cfg_addr;
            acc_wdata = cfg_wdata;
            acc_wr = cfg_wr;
            acc_rd = cfg_rd && !cfg_wr;
         end
         dgpio_pkg::DGPIO_ACC_WIN: begin
            acc_addr = win_idx;
            acc_wdata = io_wdata;
            acc_wr = io_wr;
            acc_rd = io_rd && !io_wr;
         end
         default: begin
            acc_addr = 8'h00;
            acc_wdata = 8'h00;
            acc_wr = 1'b0;
            acc_rd = 1'b0;
         end
      endcase
   end

   // window control and base registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= `DGPIO_ZERO_RST;
         base_hi_r <= `DGPIO_ZERO_RST;
         base_lo_r <= `DGPIO_ZERO_RST;
      end else if (acc_wr) begin
         if (acc_addr == `DGPIO_OFF_CTRL)
            ctrl_r <= acc_wdata & `DGPIO_CTRL_MASK; // RL13 RL17
         else if (acc_addr == `DGPIO_OFF_BASE_HI)
            base_hi_r <= acc_wdata & `DGPIO_BASE_HI_MASK; // RL14
         else if (acc_addr == `DGPIO_OFF_BASE_LO)
            base_lo_r <= acc_wdata; // RL14
      end
   end

   // narrow port alternate function
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) n_alt_r <= `DGPIO_ZERO_RST;
      else if (!narrow_port_reset_n) n_alt_r <= `DGPIO_ZERO_RST; // RL12
      else if (acc_wr && acc_addr == `DGPIO_OFF_N_ALT)
         n_alt_r <= acc_wdata & `DGPIO_N_ALT_MASK; // RL10 RL17
   end

   // wide port alternate function
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) w_alt_r <= `DGPIO_ZERO_RST;
      else if (!wide_port_reset_n) w_alt_r <= `DGPIO_ZERO_RST; // RL12
      else if (acc_wr && acc_addr == `DGPIO_OFF_W_ALT)
         w_alt_r <= acc_wdata; // RL11
   end

   // fixed function values per pin
   assign n_alt_val = {2'b00, alt_src.beep_out, alt_src.green_led_out,
      4'h0}; // RL10
   assign w_alt_val = {2{alt_src.yellow_led_out, alt_src.beep_out,
      alt_src.system_mgmt_irq_out, alt_src.watchdog_timeout_out}}; // RL11

   dgpio_port #(
      .IMPL(`DGPIO_N_IMPL),
      .DIR_RST(`DGPIO_N_DIR_RST)
   ) u_narrow (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .port_rst_n(narrow_port_reset_n),
      .active(narrow_port_active),
      .dir_we(acc_wr && acc_addr == `DGPIO_OFF_N_DIR),
      .data_we(acc_wr && acc_addr == `DGPIO_OFF_N_DATA),
      .pol_we(acc_wr && acc_addr == `DGPIO_OFF_N_POL),
      .stat_rd(acc_rd && acc_addr == `DGPIO_OFF_N_STAT),
      .wdata(acc_wdata),
      .pin_in(narrow_port_pins_in),
      .alt_en(n_alt_r),
      .alt_val(n_alt_val),
      .regs(n_regs),
      .pin_out(narrow_port_pins_out),
      .pin_oe(narrow_port_pins_oe)
   );

   dgpio_port #(
      .IMPL(`DGPIO_W_IMPL),
      .DIR_RST(`DGPIO_W_DIR_RST)
   ) u_wide (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .port_rst_n(wide_port_reset_n),
      .active(wide_port_active),
      .dir_we(acc_wr && acc_addr == `DGPIO_OFF_W_DIR),
      .data_we(acc_wr && acc_addr == `DGPIO_OFF_W_DATA),
      .pol_we(acc_wr && acc_addr == `DGPIO_OFF_W_POL),
      .stat_rd(acc_rd && acc_addr == `DGPIO_OFF_W_STAT),
      .wdata(acc_wdata),
      .pin_in(wide_port_pins_in),
      .alt_en(w_alt_r),
      .alt_val(w_alt_val),
      .regs(w_regs),
      .pin_out(wide_port_pins_out),
      .pin_oe(wide_port_pins_oe)
   );

   // read mux, unmapped offsets read zero
   always_comb begin
      if (acc_addr == `DGPIO_OFF_CTRL) rd_mux = ctrl_r;
      else if (acc_addr == `DGPIO_OFF_BASE_HI) rd_mux = base_hi_r;
      else if (acc_addr == `DGPIO_OFF_BASE_LO) rd_mux = base_lo_r;
      else if (acc_addr == `DGPIO_OFF_N_DIR) rd_mux = n_regs.dir;
      else if (acc_addr == `DGPIO_OFF_N_DATA) rd_mux = n_regs.data;
      else if (acc_addr == `DGPIO_OFF_N_POL) rd_mux = n_regs.pol;
      else if (acc_addr == `DGPIO_OFF_N_STAT) rd_mux = n_regs.stat;
      else if (acc_addr == `DGPIO_OFF_W_DIR) rd_mux = w_regs.dir;
      else if (acc_addr == `DGPIO_OFF_W_DATA) rd_mux = w_regs.data;
      else if (acc_addr == `DGPIO_OFF_W_POL) rd_mux = w_regs.pol;
      else if (acc_addr == `DGPIO_OFF_W_STAT) rd_mux = w_regs.stat;
      else if (acc_addr == `DGPIO_OFF_N_ALT) rd_mux = n_alt_r;
      else if (acc_addr == `DGPIO_OFF_W_ALT) rd_mux = w_alt_r;
      else rd_mux = 8'h00; // RL17
   end

   // read data captured one edge after the strobe
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_rdata <= 8'h00;
         io_rdata <= 8'h00;
      end else begin
         if (acc_rd && acc_src == dgpio_pkg::DGPIO_ACC_CFG)
            cfg_rdata <= rd_mux; // RL7
         if (acc_rd && acc_src == dgpio_pkg::DGPIO_ACC_WIN)
            io_rdata <= rd_mux;
      end
   end

   // helper edge view for the checks below
   logic [7:0] w_lvl_d_r, n_lvl_d_r;
   logic [7:0] w_edge, n_edge;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         w_lvl_d_r <= 8'h00;
         n_lvl_d_r <= 8'h00;
      end else begin
         w_lvl_d_r <= w_regs.lvl;
         n_lvl_d_r <= n_regs.lvl;
      end
   end
   assign w_edge = (w_regs.lvl ^ w_lvl_d_r) & {8{wide_port_active}};
   assign n_edge = (n_regs.lvl ^ n_lvl_d_r) & {8{narrow_port_active}};

   default clocking dgpio_cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n || !narrow_port_reset_n || !wide_port_reset_n);

   a_narrow_pin_oe: assert property ( // RL1
      narrow_port_pins_oe == ($past(narrow_port_active) ?
      (($past(~n_regs.dir) & `DGPIO_N_IMPL) | $past(n_alt_r)) : 8'h00))
      else $error("narrow port drive enable wrong");

   a_wide_pin_oe: assert property ( // RL2
      wide_port_pins_oe == ($past(wide_port_active) ?
      ($past(~w_regs.dir) | $past(w_alt_r)) : 8'h00))
      else $error("wide port drive enable wrong");

   a_wide_out_data: assert property ( // RL3
      ((wide_port_pins_out ^ $past(w_regs.data ^ w_regs.pol)) &
      $past(~w_alt_r & ~w_regs.dir)) == 8'h00)
      else $error("wide output pin differs from data");

   a_input_readback: assert property ( // RL4
      ((w_regs.data ^ w_regs.lvl ^ w_regs.pol) & w_regs.dir) == 8'h00)
      else $error("input bit read value wrong");

   a_input_wr_ignore: assert property ( // RL4
      (cfg_wr && cfg_addr == `DGPIO_OFF_W_DATA && w_regs.dir == 8'hff &&
      w_alt_r == 8'h00)
      |=> ##1 $stable(wide_port_pins_out))
      else $error("write changed an input bit");

   a_edge_sets_stat: assert property ( // RL6
      (|w_edge) |=> ((w_regs.stat & $past(w_edge)) == $past(w_edge)))
      else $error("wide edge did not set status");

   a_edge_beats_clr: assert property ( // RL16
      (cfg_rd && !cfg_wr && cfg_addr == `DGPIO_OFF_N_STAT && (|n_edge))
      |=> ((n_regs.stat & $past(n_edge)) == $past(n_edge)))
      else $error("edge lost under status read");

   a_stat_read_clr: assert property ( // RL7
      (cfg_rd && !cfg_wr && cfg_addr == `DGPIO_OFF_W_STAT && !(|w_edge))
      |=> (w_regs.stat == 8'h00) && (cfg_rdata == $past(w_regs.stat)))
      else $error("status read did not return then clear");

   a_narrow_reserved: assert property ( // RL9
      ((n_regs.stat | n_regs.dir | n_regs.pol | n_regs.data) &
      ~`DGPIO_N_IMPL) == 8'h00)
      else $error("narrow reserved bits not zero");

   a_narrow_alt_out: assert property ( // RL10
      ((narrow_port_pins_out ^ $past(n_alt_val)) & $past(n_alt_r)) == 8'h00)
      else $error("narrow alternate output wrong");

   a_wide_alt_out: assert property ( // RL11
      ((wide_port_pins_out ^ $past(w_alt_val)) & $past(w_alt_r)) == 8'h00)
      else $error("wide alternate output wrong");

   a_window_closed: assert property ( // RL13
      !ctrl_r[`DGPIO_CTRL_WIN_BIT] |-> !io_hit)
      else $error("window answered while closed");

   a_port_reset_vals: assert property ( // RL12
      disable iff (!rst_n)
      $rose(wide_port_reset_n) |-> (w_regs.dir == `DGPIO_W_DIR_RST) &&
      (w_regs.pol == 8'h00) && (w_regs.stat == 8'h00) && (w_alt_r == 8'h00))
      else $error("wide port reset values wrong");

   // narrow port drive, read clear, idle port and window write
   a_narrow_out_data: assert property ( // RL3
      ((narrow_port_pins_out ^ $past(n_regs.data ^ n_regs.pol)) &
      $past(~n_alt_r & ~n_regs.dir) & `DGPIO_N_IMPL) == 8'h00)
      else $error("narrow output pin differs from data");

   a_narrow_read_clr: assert property ( // RL7
      (cfg_rd && !cfg_wr && cfg_addr == `DGPIO_OFF_N_STAT && !(|n_edge))
      |=> (n_regs.stat == 8'h00) && (cfg_rdata == $past(n_regs.stat)))
      else $error("narrow status read did not clear");

   a_idle_no_status: assert property ( // RL15
      !wide_port_active |=>
      ((w_regs.stat & ~$past(w_regs.stat)) == 8'h00))
      else $error("inactive port captured an edge");

   a_window_write: assert property ( // RL13
      (io_hit && io_wr && !cfg_wr && !cfg_rd && io_addr[2:0] == 3'h6)
      |=> (w_regs.pol == $past(io_wdata)))
      else $error("window write did not land");

   c_stat_read: cover property (
      (|w_regs.stat) ##1 (cfg_rd && cfg_addr == `DGPIO_OFF_W_STAT));
   c_window_write: cover property (io_hit && io_wr);
   c_window_read: cover property (io_hit && io_rd);
   c_alt_drive: cover property ((|w_alt_r) && (|wide_port_pins_oe));
   c_edge_in_read: cover property (
      cfg_rd && cfg_addr == `DGPIO_OFF_N_STAT && (|n_edge));

endmodule : dgpio_bank
`default_nettype wire

// file: src/dgpio_map.svh
// Overview of operation
// RL1 - narrow direction bits 3:0, 0 output, reset input
// RL2 - wide direction bits 7:0, 0 output, reset input
// RL3 - output bit data is stored and driven
// RL4 - input bit reads pin, writes ignored
// RL5 - polarity bit inverts between register and pin
// RL6 - any pin edge sets its status bit
// RL7 - status read returns bits then clears them
// RL8 - wide status bits map to pins in order
// RL9 - narrow status only bits 3:0, rest reserved
// RL10 - narrow alt bits route beep and green
// RL11 - wide alt bits route led, beep, irq, watchdog
// RL12 - each port resets only by its reset
// RL13 - control bit 3 opens the I/O window
// RL14 - two bytes hold window base, reset zero
// RL15 - each port needs its own activation enable
// RL16 - pins synchronised, edge beats read clear
// RL17 - reserved bits read zero, ignore writes
`ifndef DGPIO_MAP_SVH
`define DGPIO_MAP_SVH

`define DGPIO_OFF_CTRL 8'h30
`define DGPIO_OFF_BASE_HI 8'h60
`define DGPIO_OFF_BASE_LO 8'h61
`define DGPIO_OFF_N_DIR 8'he0
`define DGPIO_OFF_N_DATA 8'he1
`define DGPIO_OFF_N_POL 8'he2
`define DGPIO_OFF_N_STAT 8'he3
`define DGPIO_OFF_W_DIR 8'he4
`define DGPIO_OFF_W_DATA 8'he5
`define DGPIO_OFF_W_POL 8'he6
`define DGPIO_OFF_W_STAT 8'he7
`define DGPIO_OFF_N_ALT 8'hec
`define DGPIO_OFF_W_ALT 8'hed

`define DGPIO_CTRL_MASK 8'h08
`define DGPIO_CTRL_WIN_BIT 3
`define DGPIO_N_IMPL 8'h0f
`define DGPIO_N_ALT_MASK 8'h30
`define DGPIO_W_IMPL 8'hff
`define DGPIO_N_DIR_RST 8'h0f
`define DGPIO_W_DIR_RST 8'hff
`define DGPIO_ZERO_RST 8'h00
`define DGPIO_BASE_HI_MASK 8'h0f
`define DGPIO_WIN_SPAN_BITS 3

`endif

// file: src/dgpio_pkg.sv
package dgpio_pkg;

   // register view of one port
   typedef struct packed {
      logic [7:0] dir;
      logic [7:0] data;
      logic [7:0] pol;
      logic [7:0] stat;
      logic [7:0] lvl;
   } dgpio_regs_t;

   // function sources that may be routed onto pins
   typedef struct packed {
      logic yellow_led_out;
      logic green_led_out;
      logic beep_out;
      logic system_mgmt_irq_out;
      logic watchdog_timeout_out;
   } dgpio_alt_src_t;

   // which path owns the current access
   typedef enum logic [1:0] {
      DGPIO_ACC_IDLE = 2'b00,
      DGPIO_ACC_CFG = 2'b01,
      DGPIO_ACC_WIN = 2'b10
   } dgpio_acc_t;

endpackage : dgpio_pkg

// file: src/dgpio_port.sv
`timescale 1ns/1ps
`default_nettype none
module dgpio_port #(
   parameter logic [7:0] IMPL = 8'hff,
   parameter logic [7:0] DIR_RST = 8'hff
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic port_rst_n,
   input wire logic active,
   input wire logic dir_we,
   input wire logic data_we,
   input wire logic pol_we,
   input wire logic stat_rd,
   input wire logic [7:0] wdata,
   input wire logic [7:0] pin_in,
   input wire logic [7:0] alt_en,
   input wire logic [7:0] alt_val,
   output var dgpio_pkg::dgpio_regs_t regs,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe
);
   logic [7:0] dir_r, data_r, pol_r, stat_r;
   logic [7:0] sync1_r, sync2_r, lvl_d_r;
   logic [7:0] edge_w;

   // two-stage synchroniser, then one delay for edges
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= 8'h00;
         sync2_r <= 8'h00;
         lvl_d_r <= 8'h00;
      end else begin
         sync1_r <= pin_in; // RL16
         sync2_r <= sync1_r;
         lvl_d_r <= sync2_r;
      end
   end

   // rising or falling edge on implemented bits
   assign edge_w = (sync2_r ^ lvl_d_r) & IMPL & {8{active}}; // RL6

   // direction register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) dir_r <= DIR_RST;
      else if (!port_rst_n) dir_r <= DIR_RST; // RL12
      else if (dir_we) dir_r <= wdata & IMPL; // RL1 RL2 RL17
   end

   // data register, input bits keep their value
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) data_r <= 8'h00;
      else if (!port_rst_n) data_r <= 8'h00; // RL12
      else if (data_we) data_r <= (data_r & dir_r) | (wdata & ~dir_r & IMPL); // RL3 RL4
   end

   // polarity register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) pol_r <= 8'h00;
      else if (!port_rst_n) pol_r <= 8'h00; // RL12
      else if (pol_we) pol_r <= wdata & IMPL; // RL5
   end

   // sticky edge status, a new edge beats the read clear
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) stat_r <= 8'h00;
      else if (!port_rst_n) stat_r <= 8'h00; // RL12
      else stat_r <= (stat_rd ? 8'h00 : stat_r) | edge_w; // RL7 RL16 RL8
   end

   // pin drive, alternate function replaces data
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out <= 8'h00;
         pin_oe <= 8'h00;
      end else begin
         pin_out <= (alt_en & alt_val) | (~alt_en & (data_r ^ pol_r)); // RL3 RL5
         pin_oe <= active ? ((~dir_r & IMPL) | alt_en) : 8'h00; // RL15
      end
   end

   // register view, input bits show the pin
   always_comb begin
      regs.dir = dir_r;
      regs.data = ((data_r & ~dir_r) | ((sync2_r ^ pol_r) & dir_r)) & IMPL; // RL4 RL5
      regs.pol = pol_r;
      regs.stat = stat_r; // RL9
      regs.lvl = sync2_r & IMPL;
   end

endmodule : dgpio_port
`default_nettype wire

// file: testbench/dgpio_board.sv
`timescale 1ns/1ps
`default_nettype none
// board side of one port: each pin follows the device drive while the device
// drives it, otherwise the level that the board puts on it
module dgpio_board (
   input wire logic [7:0] pins_out,
   input wire logic [7:0] pins_oe,
   input wire logic [7:0] board_level,
   output logic [7:0] pins_in
);
   // wire resolution per pin, device drive wins over the board level
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pins_in[i] = pins_oe[i] ? pins_out[i] : board_level[i];
      end
   end
endmodule : dgpio_board
`default_nettype wire

// file: testbench/dgpio_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dgpio_bank_tb;
   logic core_clk, rst_n, n_rst_n, w_rst_n, n_act, w_act;
   logic cfg_wr, cfg_rd, io_wr, io_rd, io_hit, hit;
   logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, io_wdata, io_rdata, rdv;
   logic [11:0] io_addr;
   logic [7:0] n_in, n_out, n_oe, w_in, w_out, w_oe, n_lvl, w_lvl;
   dgpio_pkg::dgpio_alt_src_t alt_src;
   int failures, num_checks, cycles;

   dgpio_bank i_dut (
      .core_clk(core_clk), .rst_n(rst_n),
      .narrow_port_reset_n(n_rst_n), .wide_port_reset_n(w_rst_n),
      .narrow_port_active(n_act), .wide_port_active(w_act),
      .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit),
      .alt_src(alt_src),
      .narrow_port_pins_in(n_in), .narrow_port_pins_out(n_out),
      .narrow_port_pins_oe(n_oe),
      .wide_port_pins_in(w_in), .wide_port_pins_out(w_out),
      .wide_port_pins_oe(w_oe)
   );
   dgpio_board i_nboard (.pins_out(n_out), .pins_oe(n_oe),
      .board_level(n_lvl), .pins_in(n_in));
   dgpio_board i_wboard (.pins_out(w_out), .pins_oe(w_oe),
      .board_level(w_lvl), .pins_in(w_in));

   // clock, 50 ns period
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (cycles > 4000) begin
         failures++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask : cyc

   // one write strobe across one rising edge, then one idle edge
   task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
      cfg_addr = a;
      cfg_wdata = d;
      cfg_wr = 1'b1;
      @(negedge core_clk);
      cfg_wr = 1'b0;
      @(negedge core_clk);
   endtask : cfg_write

   // one read strobe, then one idle edge; data stands until next read
   task automatic cfg_read(input logic [7:0] a);
      cfg_addr = a;
      cfg_rd = 1'b1;
      @(negedge core_clk);
      cfg_rd = 1'b0;
      @(negedge core_clk);
   endtask : cfg_read

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      cfg_read(a);
      chk(cfg_rdata, exp);
   endtask : rd_chk

   // window access; hit sampled while the strobe stands
   task automatic io_acc(input logic wr, input logic [11:0] a,
      input logic [7:0] d);
      io_addr = a;
      io_wdata = d;
      io_wr = wr;
      io_rd = ~wr;
      #1 hit = io_hit;
      @(negedge core_clk);
      io_wr = 1'b0;
      io_rd = 1'b0;
      rdv = io_rdata;
      @(negedge core_clk);
   endtask : io_acc

   task automatic test_reset();
      logic [7:0] ad[14] = '{8'h30, 8'h60, 8'h61, 8'he0, 8'he1, 8'he2,
         8'he3, 8'he4, 8'he5, 8'he6, 8'he7, 8'hec, 8'hed, 8'h50};
      logic [7:0] ex[14] = '{8'h00, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h00,
         8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      chk(w_oe, 8'h00);
      chk(n_oe, 8'h00);
      for (int i = 0; i < 14; i++) begin
         rd_chk(ad[i], ex[i]);
      end
      $display("test reset done");
   endtask : test_reset

   task automatic test_output();
      cfg_write(8'he4, 8'h00);
      cfg_write(8'he5, 8'ha5);
      cfg_write(8'he6, 8'h0f);
      cyc(3);
      chk(w_out, 8'haa);
      chk(w_oe, 8'hff);
      rd_chk(8'he5, 8'ha5);
      cfg_write(8'he0, 8'hf0);
      rd_chk(8'he0, 8'h00);
      cfg_write(8'he1, 8'h0a);
      cfg_write(8'he2, 8'hff);
      rd_chk(8'he2, 8'h0f);
      cyc(3);
      chk(n_out & 8'h0f, 8'h05);
      chk(n_oe, 8'h0f);
      $display("test output done");
   endtask : test_output

   task automatic test_input();
      cfg_write(8'he4, 8'hff);
      cfg_write(8'he6, 8'h00);
      cfg_write(8'he0, 8'h0f);
      cyc(5);
      rd_chk(8'he7, 8'haf);
      rd_chk(8'he3, 8'h0f);
      w_lvl = 8'h3c;
      n_lvl = 8'hff;
      cyc(5);
      rd_chk(8'he7, 8'h3c);
      rd_chk(8'he7, 8'h00);
      rd_chk(8'he3, 8'h0f);
      rd_chk(8'he5, 8'h3c);
      cfg_write(8'he5, 8'hff);
      rd_chk(8'he5, 8'h3c);
      cfg_write(8'he6, 8'hff);
      cyc(4);
      rd_chk(8'he5, 8'hc3);
      rd_chk(8'he1, 8'h00);
      $display("test input done");
   endtask : test_input

   task automatic test_alt();
      cfg_write(8'he6, 8'h00);
      cfg_write(8'hed, 8'hff);
      cfg_write(8'hec, 8'hff);
      alt_src = 5'b10010;
      cyc(3);
      chk(w_out, 8'haa);
      chk(w_oe, 8'hff);
      chk(n_out & 8'h30, 8'h00);
      alt_src = 5'b01101;
      cyc(3);
      chk(w_out, 8'h55);
      chk(n_out & 8'h30, 8'h30);
      chk(n_oe & 8'h30, 8'h30);
      rd_chk(8'hec, 8'h30);
      rd_chk(8'hed, 8'hff);
      $display("test alt done");
   endtask : test_alt

   task automatic test_window();
      cfg_write(8'h30, 8'hff);
      rd_chk(8'h30, 8'h08);
      cfg_write(8'h60, 8'h12);
      rd_chk(8'h60, 8'h02);
      cfg_write(8'h61, 8'h40);
      io_acc(1'b0, 12'h244, 8'h00);
      chk({7'h00, hit}, 8'h01);
      chk(rdv, 8'hff);
      io_acc(1'b1, 12'h246, 8'h5a);
      rd_chk(8'he6, 8'h5a);
      io_acc(1'b0, 12'h242, 8'h00);
      chk(rdv, 8'h0f);
      io_acc(1'b0, 12'h23f, 8'h00);
      chk({7'h00, hit}, 8'h00);
      cfg_write(8'h30, 8'h00);
      io_acc(1'b1, 12'h246, 8'h11);
      chk({7'h00, hit}, 8'h00);
      rd_chk(8'he6, 8'h5a);
      $display("test window done");
   endtask : test_window

   task automatic test_port();
      w_act = 1'b0;
      cyc(3);
      chk(w_oe, 8'h00);
      w_act = 1'b1;
      w_rst_n = 1'b0;
      cyc(1);
      w_rst_n = 1'b1;
      cyc(4);
      rd_chk(8'he4, 8'hff);
      rd_chk(8'he6, 8'h00);
      rd_chk(8'hed, 8'h00);
      cfg_read(8'he7); // drain edges left by the port reset
      rd_chk(8'hec, 8'h30);
      rd_chk(8'he2, 8'h0f);
      w_act = 1'b0;
      w_lvl = 8'hc3;
      cyc(5);
      rd_chk(8'he7, 8'h00);
      w_act = 1'b1;
      $display("test port done");
   endtask : test_port

   // an edge that arrives with the status read stays set
   task automatic test_race();
      n_lvl = 8'hfe;
      cyc(2);
      cfg_read(8'he3);
      chk(cfg_rdata, 8'h00);
      rd_chk(8'he3, 8'h01);
      $display("test race done");
   endtask : test_race

   // drive everything at time zero, reset for 2 cycles, run the tests
   initial begin
      rst_n = 1'b0;
      n_rst_n = 1'b1;
      w_rst_n = 1'b1;
      n_act = 1'b1;
      w_act = 1'b1;
      cfg_addr = 8'h00;
      cfg_wdata = 8'h00;
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      io_addr = 12'h000;
      io_wdata = 8'h00;
      io_wr = 1'b0;
      io_rd = 1'b0;
      alt_src = 5'b00000;
      n_lvl = 8'h00;
      w_lvl = 8'h00;
      failures = 0;
      num_checks = 0;
      cycles = 0;
      cyc(2);
      rst_n = 1'b1;
      cyc(1);
      test_reset();
      test_output();
      test_input();
      test_alt();
      test_window();
      test_port();
      test_race();
      finish_test();
   end
endmodule : dgpio_bank_tb
`default_nettype wire
